// File: include/tpo_pkg.sv
package tpo_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int unsigned TPO_ADDR_W = 12;
    localparam logic [7:0] TPO_IDX_MODE = 8'hB8;
    localparam logic [7:0] TPO_IDX_COUNT = 8'hB9;
    localparam logic [7:0] TPO_IDX_RELOAD = 8'hBA;
    localparam logic [7:0] TPO_IDX_DUTY = 8'hBB;
    localparam logic [7:0] TPO_IDX_ROUTE = 8'hC4;
    localparam logic [7:0] TPO_IDX_STATUS = 8'hC5;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned TPO_MODE_OE_BIT = 0;
    localparam int unsigned TPO_MODE_ONE_PULSE_BIT = 1;
    localparam int unsigned TPO_MODE_RUN_BIT = 7;
    localparam int unsigned TPO_STAT_FLAG_BIT = 0;
    localparam int unsigned TPO_STAT_IEN_BIT = 1;
    localparam int unsigned TPO_ROUTE_FIRST_BIT = 0;
    localparam int unsigned TPO_ROUTE_SECOND_BIT = 1;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] TPO_REG_RESET = 8'h00;
    localparam logic [7:0] TPO_COUNT_FULL = 8'hFF;
    localparam int unsigned TPO_PRESCALE_W = 7;
    localparam logic [1:0] TPO_RESP_OKAY = 2'h0;
    localparam logic [1:0] TPO_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic timer_run_enable;
        logic [2:0] prescale_select;
        logic clk_src_ext;
        logic clk_src_hosc;
        logic one_pulse_mode;
        logic pwm_output_enable;
    } tpo_mode_t;

    typedef enum logic [2:0] {
        TPO_SEL_MODE,
        TPO_SEL_COUNT,
        TPO_SEL_RELOAD,
        TPO_SEL_DUTY,
        TPO_SEL_ROUTE,
        TPO_SEL_STATUS,
        TPO_SEL_NONE
    } tpo_sel_t;

endpackage

// File: core/tpo_prescaler.sv
module tpo_prescaler
    import tpo_pkg::*;
#(
    parameter int unsigned DIV_W = TPO_PRESCALE_W
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic run,
    input wire logic [2:0] prescale_select,
    output logic tick
);

    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] mask;

    // ------------------------------------------------------------
    // Divide select: code 000 divides by 128, code 111 by 1
    // ------------------------------------------------------------
    // rate from code
    assign mask = DIV_W'((1 << (3'd7 - prescale_select)) - 1);
    assign tick = run && ((div_q & mask) == mask);

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B || !run) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end

endmodule // tpo_prescaler

// File: core/tpo_pin_mux.sv
module tpo_pin_mux #(
    parameter int unsigned CHANNELS = 2
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic pwm_level,
    input wire logic [CHANNELS-1:0] drive_en,
    input wire logic [CHANNELS-1:0] gpio_level,
    output logic [CHANNELS-1:0] pin_level,
    output logic [CHANNELS-1:0] pin_is_pwm
);

    // ------------------------------------------------------------
    // Per-pin choice between carrier and own GPIO state
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            pin_level <= '0;
            pin_is_pwm <= '0;
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                pin_level[i] <= drive_en[i] ? pwm_level : gpio_level[i];
                pin_is_pwm[i] <= drive_en[i];
            end
        end
    end

endmodule // tpo_pin_mux

// File: core/tpo_pwm_timer.sv
// How it works
// - Pin carries PWM only with timer running, output enabled, route bit set.
// - Timer or output enable off returns pin to its own GPIO level.
// - Each period with duty above reload starts high and ends low.
// - Counter loads reload value at timer enable and at every overflow.
// - Counter equal to duty compare ends the high phase.
// - Overflow at FF ends the period, reloads the counter and drives output high if duty is above reload.
// - New duty or period values take effect only from the next period.
// - Route bit 0 picks first pin, bit 1 second pin; clear means GPIO.
// - Reload value sets resolution, 00 gives 256 steps, 80 gives 128.
// - Duty compare not above reload keeps output low all period.
// - Overflow flag and interrupt request keep working during PWM.
// - Clearing output enable gates the carrier while the timer keeps counting.
// - One-pulse mode off runs continuous; on with output enable gives one period.
// - Single pulse end clears output enable and returns pins to GPIO.
// - One-pulse overflow sets the flag; software re-arms each further pulse.
// - Mode bit 0 output enable, bit 1 one-pulse, bit 7 run; all reset 0.
// - Three-bit prescale divides by 128 at code 000 down to 1 at 111.
// - Reload write lands in a buffer, moved to active at overflow.
//
// Decided for this implementation: the AXI4-Lite slave port.
module tpo_pwm_timer
    import tpo_pkg::*;
#(
    parameter int unsigned ADDR_W = TPO_ADDR_W
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [1:0] GPIO_LEVEL,
    output logic PWM_OUT_FIRST,
    output logic PWM_OUT_SECOND,
    output logic [1:0] PIN_IS_PWM,
    output logic OVERFLOW_IRQ
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic tpo_sel_t decode(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-3:0] idx;
        idx = addr[ADDR_W-1:2];
        if (addr[1:0] != 2'h0) begin
            return TPO_SEL_NONE;
        end
        case (idx)
            (ADDR_W-2)'(TPO_IDX_MODE): return TPO_SEL_MODE;
            (ADDR_W-2)'(TPO_IDX_COUNT): return TPO_SEL_COUNT;
            (ADDR_W-2)'(TPO_IDX_RELOAD): return TPO_SEL_RELOAD;
            (ADDR_W-2)'(TPO_IDX_DUTY): return TPO_SEL_DUTY;
            (ADDR_W-2)'(TPO_IDX_ROUTE): return TPO_SEL_ROUTE;
            (ADDR_W-2)'(TPO_IDX_STATUS): return TPO_SEL_STATUS;
            default: return TPO_SEL_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic aw_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic w_held_q;
    logic [7:0] w_data_q;
    logic w_lane_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic do_write;
    tpo_sel_t wr_sel;
    tpo_sel_t rd_sel;
    logic wr_en;
    logic [7:0] wr_byte;

    tpo_mode_t mode_q;
    logic [7:0] count_q;
    logic [7:0] reload_buf_q;
    logic [7:0] reload_act_q;
    logic [7:0] duty_q;
    logic [7:0] duty_act_q;
    logic [1:0] route_q;
    logic flag_q;
    logic irq_en_q;
    logic run_prev_q;
    logic pwm_q;
    logic in_pulse_q;

    logic run;
    logic start;
    logic tick;
    logic ovf;
    logic period_edge;
    logic pulse_end;
    logic [1:0] drive_en;
    logic [1:0] pin_level;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    assign S_AXI_AWREADY = !aw_held_q && !bvalid_q;
    assign S_AXI_WREADY = !w_held_q && !bvalid_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign wr_sel = decode(aw_addr_q);
    assign wr_en = do_write && w_lane_q;
    assign wr_byte = w_data_q;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_held_q <= 1'b0;
            w_data_q <= TPO_REG_RESET;
            w_lane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= TPO_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_q <= 1'b1;
                w_data_q <= S_AXI_WDATA[7:0];
                w_lane_q <= S_AXI_WSTRB[0];
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (wr_sel == TPO_SEL_NONE) ? TPO_RESP_SLVERR : TPO_RESP_OKAY;
            end else if (bvalid_q && S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;
    assign rd_sel = decode(S_AXI_ARADDR);

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            rvalid_q <= 1'b0;
            rresp_q <= TPO_RESP_OKAY;
            rdata_q <= '0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_q <= 1'b1;
            rresp_q <= TPO_RESP_OKAY;
            case (rd_sel)
                TPO_SEL_MODE: rdata_q <= {24'h000000, mode_q};
                TPO_SEL_COUNT: rdata_q <= {24'h000000, count_q};
                TPO_SEL_RELOAD: rdata_q <= '0;
                TPO_SEL_DUTY: rdata_q <= {24'h000000, duty_q};
                TPO_SEL_ROUTE: rdata_q <= {30'h00000000, route_q};
                TPO_SEL_STATUS: rdata_q <= {30'h00000000, irq_en_q, flag_q};
                default: begin
                    rdata_q <= '0;
                    rresp_q <= TPO_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Timing events
    // ------------------------------------------------------------
    assign run = mode_q.timer_run_enable;
    assign start = run && !run_prev_q;
    assign ovf = tick && (count_q == TPO_COUNT_FULL);
    assign period_edge = start || ovf;
    assign pulse_end = ovf && in_pulse_q;

    tpo_prescaler #(
        .DIV_W(TPO_PRESCALE_W)
    ) u_prescaler (
        .CORE_CLK(CORE_CLK),
        .RST_B(RST_B),
        .run(run),
        .prescale_select(mode_q.prescale_select),
        .tick(tick)
    );

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= run;
        end
    end

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            mode_q <= tpo_mode_t'(TPO_REG_RESET);
        end else if (wr_en && wr_sel == TPO_SEL_MODE) begin
            mode_q <= tpo_mode_t'(wr_byte);
        end else if (pulse_end) begin
            mode_q.pwm_output_enable <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            count_q <= TPO_REG_RESET;
        end else if (wr_en && wr_sel == TPO_SEL_COUNT) begin
            count_q <= wr_byte;
        end else if (period_edge) begin
            count_q <= reload_buf_q;
        end else if (tick) begin
            count_q <= count_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Reload, duty and routing registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            reload_buf_q <= TPO_REG_RESET;
            reload_act_q <= TPO_REG_RESET;
        end else begin
            if (wr_en && wr_sel == TPO_SEL_RELOAD) begin
                reload_buf_q <= wr_byte;
            end
            if (period_edge) begin
                reload_act_q <= reload_buf_q;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            duty_q <= TPO_REG_RESET;
            duty_act_q <= TPO_REG_RESET;
        end else begin
            if (wr_en && wr_sel == TPO_SEL_DUTY) begin
                duty_q <= wr_byte;
            end
            if (period_edge) begin
                duty_act_q <= duty_q;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            route_q <= '0;
        end else if (wr_en && wr_sel == TPO_SEL_ROUTE) begin
            route_q <= wr_byte[1:0];
        end
    end

    // ------------------------------------------------------------
    // Overflow flag and interrupt enable
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            flag_q <= 1'b0;
            irq_en_q <= 1'b0;
        end else begin
            if (wr_en && wr_sel == TPO_SEL_STATUS) begin
                irq_en_q <= wr_byte[TPO_STAT_IEN_BIT];
            end
            if (ovf) begin
                flag_q <= 1'b1;
            end else if (wr_en && wr_sel == TPO_SEL_STATUS && !wr_byte[TPO_STAT_FLAG_BIT]) begin
                flag_q <= 1'b0;
            end
        end
    end

    assign OVERFLOW_IRQ = flag_q && irq_en_q;

    // ------------------------------------------------------------
    // Waveform level
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B || !run) begin
            pwm_q <= 1'b0;
        end else if (period_edge) begin
            // duty not above reload stays low
            pwm_q <= duty_q > reload_buf_q;
        end else if (tick && (count_q + 8'h01) == duty_act_q) begin
            pwm_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Single pulse tracking
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B || !run) begin
            in_pulse_q <= 1'b0;
        end else if (period_edge) begin
            in_pulse_q <= mode_q.one_pulse_mode && mode_q.pwm_output_enable && !in_pulse_q;
        end
    end

    // ------------------------------------------------------------
    // Pin routing
    // ------------------------------------------------------------
    // drive only when all enabled
    assign drive_en = {2{run && mode_q.pwm_output_enable && (!mode_q.one_pulse_mode || in_pulse_q)}}
                      & {route_q[TPO_ROUTE_SECOND_BIT], route_q[TPO_ROUTE_FIRST_BIT]};

    tpo_pin_mux #(
        .CHANNELS(2)
    ) u_pin_mux (
        .CORE_CLK(CORE_CLK),
        .RST_B(RST_B),
        .pwm_level(pwm_q),
        .drive_en(drive_en),
        .gpio_level(GPIO_LEVEL),
        .pin_level(pin_level),
        .pin_is_pwm(PIN_IS_PWM)
    );

    assign PWM_OUT_FIRST = pin_level[0];
    assign PWM_OUT_SECOND = pin_level[1];

endmodule // tpo_pwm_timer

// File: verif/tpo_pwm_properties.sv
// ----------------------------------------
// Port checks
// ----------------------------------------
module tpo_pwm_properties
    import tpo_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [1:0] GPIO_LEVEL,
    input wire logic PWM_OUT_FIRST,
    input wire logic PWM_OUT_SECOND,
    input wire logic [1:0] PIN_IS_PWM,
    input wire logic OVERFLOW_IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    a_gpio_first_kept: assert property (!PIN_IS_PWM[0] && $past(RST_B) |-> PWM_OUT_FIRST == $past(GPIO_LEVEL[0]))
        else $error("first pin left its gpio level");
    a_gpio_second_kept: assert property (!PIN_IS_PWM[1] && $past(RST_B) |-> PWM_OUT_SECOND == $past(GPIO_LEVEL[1]))
        else $error("second pin left its gpio level");
    a_both_pins_same: assert property (PIN_IS_PWM == 2'h3 |-> PWM_OUT_FIRST == PWM_OUT_SECOND)
        else $error("routed pins differ");
    a_reset_quiet: assert property ($rose(RST_B) |-> PIN_IS_PWM == 2'h0 && !OVERFLOW_IRQ && !S_AXI_BVALID)
        else $error("outputs not cleared by reset");
    a_aw_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write accepted while response pending");
    a_ar_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read accepted while data pending");
    a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
        else $error("write response late");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read data late");
    a_b_released: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("write response not released");
    a_r_released: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("read data not released");

    c_both_routed: cover property (PIN_IS_PWM == 2'h3 && PWM_OUT_FIRST);
    c_irq_seen: cover property (OVERFLOW_IRQ);
    c_slverr_seen: cover property (S_AXI_BVALID && S_AXI_BRESP == TPO_RESP_SLVERR);
endmodule // tpo_pwm_properties

bind tpo_pwm_timer tpo_pwm_properties u_tpo_pwm_properties (.CORE_CLK, .RST_B, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_RVALID, .S_AXI_RREADY, .GPIO_LEVEL, .PWM_OUT_FIRST, .PWM_OUT_SECOND, .PIN_IS_PWM, .OVERFLOW_IRQ);

// File: verif/tpo_pin_load.sv
// ----------------------------------------
// Load on a pin, measures pulses
// ----------------------------------------
module tpo_pin_load (
    input wire logic CORE_CLK,
    input wire logic clear,
    input wire logic pin,
    output logic [8:0] high_len,
    output logic [8:0] period_len,
    output logic [7:0] n_rise
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pin_q;
    logic [8:0] run_high;
    logic [8:0] run_per;

    always_ff @(posedge CORE_CLK) begin
        pin_q <= pin;
        run_per <= run_per + 9'h001;
        run_high <= run_high + 9'(pin);
        if (clear) begin
            high_len <= 9'h000;
            period_len <= 9'h000;
            n_rise <= 8'h00;
            run_per <= 9'h000;
            run_high <= 9'h000;
        end else if (pin && !pin_q) begin
            if (n_rise != 8'h00) period_len <= run_per;
            n_rise <= n_rise + 8'h01;
            run_per <= 9'h001;
            run_high <= 9'h001;
        end else if (!pin && pin_q) begin
            high_len <= run_high;
        end
    end
endmodule // tpo_pin_load

// File: verif/testbench.sv
module testbench
    import tpo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] rl;
        logic [7:0] dt;
        logic [8:0] hi;
        logic [8:0] per;
    } tpo_row_t;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic CORE_CLK = 1'b0;
    logic RST_B = 1'b0;
    logic [11:0] S_AXI_AWADDR = 12'h000;
    logic S_AXI_AWVALID = 1'b0;
    logic [31:0] S_AXI_WDATA = 32'h0;
    logic S_AXI_WVALID = 1'b0;
    logic S_AXI_BREADY = 1'b0;
    logic [11:0] S_AXI_ARADDR = 12'h000;
    logic S_AXI_ARVALID = 1'b0;
    logic S_AXI_RREADY = 1'b0;
    logic [1:0] GPIO_LEVEL = 2'h0;
    logic load_clear = 1'b1;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, PIN_IS_PWM;
    logic [31:0] S_AXI_RDATA, d0, d1;
    logic PWM_OUT_FIRST, PWM_OUT_SECOND, OVERFLOW_IRQ;
    logic [8:0] high_len, period_len;
    logic [7:0] n_rise;
    logic [1:0] r;
    int n_errors = 0;
    int num_checks = 0;
    logic [7:0] regs [6] = '{TPO_IDX_MODE, TPO_IDX_COUNT, TPO_IDX_RELOAD, TPO_IDX_DUTY, TPO_IDX_ROUTE, TPO_IDX_STATUS};
    tpo_row_t rows [6] = '{'{8'hF1, 8'hF0, 8'hF4, 9'h004, 9'h010}, '{8'hF1, 8'hF8, 8'hF8, 9'h000, 9'h000},
        '{8'hF1, 8'h80, 8'h81, 9'h001, 9'h080}, '{8'hF1, 8'h00, 8'h80, 9'h080, 9'h100},
        '{8'hE1, 8'hF0, 8'hF4, 9'h008, 9'h020}, '{8'h81, 8'hFE, 8'hFF, 9'h080, 9'h100}};

    always #5 CORE_CLK = ~CORE_CLK;

    tpo_pwm_timer u_tpo_pwm_timer (.CORE_CLK, .RST_B, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
        .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .GPIO_LEVEL,
        .PWM_OUT_FIRST, .PWM_OUT_SECOND, .PIN_IS_PWM, .OVERFLOW_IRQ);
    tpo_pin_load u_tpo_pin_load (.CORE_CLK, .clear(load_clear), .pin(PWM_OUT_FIRST), .high_len, .period_len, .n_rise);

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic axi_wr(input logic [7:0] idx, input logic [7:0] val, input logic [1:0] exp);
        S_AXI_AWADDR <= {2'h0, idx, 2'h0};
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WDATA <= {24'h0, val};
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (S_AXI_BVALID !== 1'b1);
        // Ready stays up between writes, so a back-to-back call never drives it twice in one step
        check("bresp", 32'(S_AXI_BRESP), 32'(exp));
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        axi_wr(idx, val, TPO_RESP_OKAY);
    endtask
    task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] rr);
        S_AXI_ARADDR <= {2'h0, idx, 2'h0};
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1);
        d = S_AXI_RDATA;
        rr = S_AXI_RRESP;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] rr;
        axi_rd(idx, d, rr);
        check(what, d, exp);
    endtask
    task automatic setup(input logic [7:0] rl, input logic [7:0] dt, input logic [7:0] mode);
        wr(TPO_IDX_MODE, 8'h00);
        wr(TPO_IDX_COUNT, rl);
        wr(TPO_IDX_RELOAD, rl);
        wr(TPO_IDX_DUTY, dt);
        wr(TPO_IDX_ROUTE, 8'h03);
        load_clear <= 1'b1;
        @(posedge CORE_CLK);
        load_clear <= 1'b0;
        wr(TPO_IDX_MODE, mode);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge CORE_CLK);
        RST_B <= 1'b1;
        load_clear <= 1'b0;
        foreach (rows[i]) begin
            setup(rows[i].rl, rows[i].dt, rows[i].mode);
            repeat (3 * int'(rows[i].per) + 40) @(posedge CORE_CLK);
            check("high_len", 32'(high_len), 32'(rows[i].hi));
            check("period_len", 32'(period_len), 32'(rows[i].per));
            check("pin_is_pwm", 32'(PIN_IS_PWM), 32'h3);
        end
        $display("test rows done");
        setup(8'hF0, 8'hF4, 8'hF1);
        repeat (40) @(posedge CORE_CLK);
        wr(TPO_IDX_RELOAD, 8'hE0);
        wr(TPO_IDX_DUTY, 8'hE8);
        check("old_period", 32'(period_len), 32'h10);
        repeat (100) @(posedge CORE_CLK);
        check("new_high", 32'(high_len), 32'h8);
        check("new_period", 32'(period_len), 32'h20);
        GPIO_LEVEL <= 2'h2;
        wr(TPO_IDX_ROUTE, 8'h01);
        repeat (3) @(posedge CORE_CLK);
        check("route_one", 32'(PIN_IS_PWM), 32'h1);
        check("gpio_second", 32'(PWM_OUT_SECOND), 32'h1);
        rd_chk("flag", TPO_IDX_STATUS, 32'h1);
        wr(TPO_IDX_STATUS, 8'h03);
        check("irq", 32'(OVERFLOW_IRQ), 32'h1);
        $display("test update done");
        GPIO_LEVEL <= 2'h1;
        wr(TPO_IDX_MODE, 8'hF0);
        repeat (3) @(posedge CORE_CLK);
        check("gated", 32'(PIN_IS_PWM), 32'h0);
        check("gpio_first", 32'(PWM_OUT_FIRST), 32'h1);
        axi_rd(TPO_IDX_COUNT, d0, r);
        axi_rd(TPO_IDX_COUNT, d1, r);
        check("counting", 32'(d0 != d1), 32'h1);
        wr(TPO_IDX_MODE, 8'h00);
        wr(TPO_IDX_STATUS, 8'h02);
        check("irq_clear", 32'(OVERFLOW_IRQ), 32'h0);
        $display("test gate done");
        GPIO_LEVEL <= 2'h0;
        setup(8'hF0, 8'hF4, 8'hF3);
        repeat (60) @(posedge CORE_CLK);
        check("pulses", 32'(n_rise), 32'h1);
        rd_chk("mode_after", TPO_IDX_MODE, 32'hF2);
        check("pulse_pins", 32'(PIN_IS_PWM), 32'h0);
        rd_chk("pulse_flag", TPO_IDX_STATUS, 32'h3);
        wr(TPO_IDX_MODE, 8'hF3);
        repeat (60) @(posedge CORE_CLK);
        check("rearm", 32'(n_rise), 32'h2);
        $display("test pulse done");
        RST_B <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        RST_B <= 1'b1;
        foreach (regs[i]) rd_chk("reset_reg", regs[i], 32'h0);
        wr(TPO_IDX_MODE, 8'h7E);
        rd_chk("mode_rw", TPO_IDX_MODE, 32'h7E);
        wr(TPO_IDX_RELOAD, 8'h55);
        rd_chk("reload_wo", TPO_IDX_RELOAD, 32'h0);
        axi_wr(8'h00, 8'h11, TPO_RESP_SLVERR);
        axi_rd(8'h00, d0, r);
        check("rresp", 32'(r), 32'(TPO_RESP_SLVERR));
        $display("test reset done");
        give_verdict();
    end

    initial begin
        repeat (30000) @(posedge CORE_CLK);
        n_errors++;
        $display("mismatch watchdog expected done seen hang");
        give_verdict();
    end
endmodule // testbench
